// ### misc_exec_pkg.sv
// Shared constants for the return and miscellaneous instruction execution block
package misc_exec_pkg;

  // ---------------------------------------------------------------------------
  // Core widths and timing
  // ---------------------------------------------------------------------------
  localparam int INSTR_W        = 14;
  localparam int PC_W           = 13;
  localparam int DATA_W         = 8;
  localparam int CLKS_PER_CYCLE = 4;   // Oscillator periods per instruction cycle
  localparam int PHASE_W        = 2;
  localparam int STACK_DEPTH    = 8;

  // ---------------------------------------------------------------------------
  // Opcode patterns: an instruction matches when (instr & mask) == value
  // ---------------------------------------------------------------------------
  localparam logic [13:0] IDLE_MASK   = 14'h3f9f;
  localparam logic [13:0] IDLE_VAL    = 14'h0000;
  localparam logic [13:0] EXACT_MASK  = 14'h3fff;
  localparam logic [13:0] RET_INT_VAL = 14'h0009;
  localparam logic [13:0] RETURN_VAL  = 14'h0008;
  localparam logic [13:0] OPTLD_VAL   = 14'h0062;
  localparam logic [13:0] LIT_MASK    = 14'h3c00;
  localparam logic [13:0] RET_LIT_VAL = 14'h3400;
  localparam logic [13:0] MOVLW_VAL   = 14'h3000;
  localparam logic [13:0] JUMP_MASK   = 14'h3800;
  localparam logic [13:0] CALL_VAL    = 14'h2000;
  localparam logic [13:0] GOTO_VAL    = 14'h2800;
  localparam logic [13:0] MOVWF_MASK  = 14'h3f80;
  localparam logic [13:0] MOVWF_VAL   = 14'h0080;
  localparam logic [13:0] FILE_MOVE_MASK = 14'h3f00;
  localparam logic [13:0] FILE_MOVE_VAL  = 14'h0800;

  // Instruction fields
  localparam int DEST_BIT  = 7;
  localparam int FILE_MSB  = 6;
  localparam int JUMP_MSB  = 10;
  localparam int LIT_MSB   = 7;

  // ---------------------------------------------------------------------------
  // File register map, {bank select, 7-bit file field}
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER   = 8'h01;
  localparam logic [7:0] ADDR_OPTION  = 8'h81;
  localparam logic [7:0] ADDR_STATUS0 = 8'h03;
  localparam logic [7:0] ADDR_STATUS1 = 8'h83;
  localparam logic [7:0] ADDR_PORT    = 8'h06;
  localparam logic [7:0] ADDR_DIR     = 8'h86;
  localparam logic [7:0] ADDR_INT_CTL0 = 8'h0b;
  localparam logic [7:0] ADDR_INT_CTL1 = 8'h8b;

  // Field positions
  localparam int INT_EN_BIT = 7;   // Global interrupt enable in interrupt control
  localparam int RP0_BIT   = 5;    // Bank select in status
  localparam int Z_BIT     = 2;    // Zero flag in status
  localparam int PSA_BIT   = 3;    // Prescaler assignment: 0 means timer
  localparam int PS_MSB    = 2;
  localparam logic [7:0] STATUS_WR_MASK = 8'he7;  // Timeout and power-down bits read only

  // Reset values
  localparam logic [7:0]  OPTION_RESET = 8'hff;
  localparam logic [7:0]  STATUS_RESET = 8'h18;
  localparam logic [7:0]  INT_CTL_RESET = 8'h00;
  localparam logic [12:0] PC_RESET     = 13'h0000;

endpackage

// ### cycle_phase_if.sv
// Instruction cycle phase and enable carried from the divider to the core
`timescale 1ns/1ps
interface cycle_phase_if;
  import misc_exec_pkg::*;

  logic               cycle_en;  // One mclk pulse per instruction cycle
  logic [PHASE_W-1:0] phase;     // Oscillator period within the cycle

  modport source (output cycle_en, output phase);
  modport sink   (input cycle_en, input phase);
endinterface

// ### cycle_divider.sv
// Divider turning the oscillator clock into instruction cycle enables
`timescale 1ns/1ps
module cycle_divider #(
  parameter int RATIO = misc_exec_pkg::CLKS_PER_CYCLE
) (
  input  wire logic   mclk,
  input  wire logic   rst_n,
  cycle_phase_if.source ph
);
  import misc_exec_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (RATIO < 2 || RATIO > (1 << PHASE_W)) begin : g_bad_ratio
    $error("cycle_divider: RATIO out of range");
  end

  typedef struct packed {
    logic [PHASE_W-1:0] count;
    logic               pulse;
  } div_state_t;

  localparam logic [PHASE_W-1:0] LAST = PHASE_W'(RATIO - 1);

  div_state_t st;
  div_state_t next_st;

  // Count oscillator periods, pulse on the last one of each cycle
  always_comb begin
    next_st = st;
    next_st.pulse = (st.count == LAST - PHASE_W'(1));
    if (st.count == LAST) begin
      next_st.count = '0;
    end else begin
      next_st.count = st.count + PHASE_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ph.cycle_en = st.pulse;
  assign ph.phase    = st.count;
endmodule

// ### return_and_misc_instr_exec.sv
// Execution core for return, no-operation and option load instructions
`timescale 1ns/1ps
module return_and_misc_instr_exec #(
  parameter int STACK_DEPTH = misc_exec_pkg::STACK_DEPTH
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic [misc_exec_pkg::INSTR_W-1:0]  instr,
  input  wire logic [misc_exec_pkg::DATA_W-1:0]   port_pin_in,
  output logic      [misc_exec_pkg::PC_W-1:0]     prog_addr,
  output logic      [misc_exec_pkg::DATA_W-1:0]   port_pin_out,
  output logic      [misc_exec_pkg::DATA_W-1:0]   port_pin_oe,
  output logic      [misc_exec_pkg::DATA_W-1:0]   w_out,
  output logic      [misc_exec_pkg::DATA_W-1:0]   option_out,
  output logic      [misc_exec_pkg::DATA_W-1:0]   interrupt_control_reg,
  output logic      [misc_exec_pkg::DATA_W-1:0]   timer_count_reg,
  output logic                                    second_cycle
);
  import misc_exec_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration check and state
  // ---------------------------------------------------------------------------
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("return_and_misc_instr_exec: STACK_DEPTH must be a power of two");
  end

  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    logic [PC_W-1:0]                   pc;
    logic [DATA_W-1:0]                 w;
    logic [DATA_W-1:0]                 option;
    logic [DATA_W-1:0]                 int_ctl;
    logic [DATA_W-1:0]                 status;
    logic [DATA_W-1:0]                 timer;
    logic [DATA_W-1:0]                 prescale;
    logic [DATA_W-1:0]                 latch;
    logic [DATA_W-1:0]                 drive_en;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    logic [SP_W-1:0]                   sp;
    logic                              flush;
    logic [DATA_W-1:0]                 pin_s1;
    logic [DATA_W-1:0]                 pin_s2;
    logic [DATA_W-1:0]                 pin_s3;
    logic [DATA_W-1:0]                 pin_level;
  } core_state_t;

  localparam core_state_t RESET_STATE = '{
    pc:     PC_RESET,
    option: OPTION_RESET,
    status: STATUS_RESET,
    int_ctl: INT_CTL_RESET,
    default: '0
  };

  core_state_t st;
  core_state_t next_st;

  cycle_phase_if ph ();

  // ---------------------------------------------------------------------------
  // Instruction cycle timing
  // ---------------------------------------------------------------------------
  // Four mclk periods make one instruction cycle
  cycle_divider #(
    .RATIO (CLKS_PER_CYCLE)
  ) u_divider (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ph    (ph)
  );

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic op_is(input logic [13:0] word,
                                 input logic [13:0] mask,
                                 input logic [13:0] value);
    op_is = ((word & mask) == value);
  endfunction

  // File read; the port reads the filtered pins so a rewrite takes pin levels
  function automatic logic [7:0] file_read(input core_state_t s, input logic [7:0] addr);
    if (addr == ADDR_TIMER) begin
      file_read = s.timer;
    end else if (addr == ADDR_OPTION) begin
      file_read = s.option;
    end else if (addr == ADDR_STATUS0 || addr == ADDR_STATUS1) begin
      file_read = s.status;
    end else if (addr == ADDR_PORT) begin
      file_read = s.pin_level;
    end else if (addr == ADDR_DIR) begin
      file_read = ~s.drive_en;
    end else if (addr == ADDR_INT_CTL0 || addr == ADDR_INT_CTL1) begin
      file_read = s.int_ctl;
    end else begin
      file_read = '0;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Locals are given values first so every path assigns them
  always_comb begin
    logic [7:0]      faddr;
    logic [7:0]      fdata;
    logic [7:0]      wr_data;
    logic            wr_en;
    logic [7:0]      rate_mask;
    logic            tick;
    logic [SP_W-1:0] sp_dn;
    faddr     = {st.status[RP0_BIT], instr[FILE_MSB:0]};  // Bank bit over 7-bit field
    fdata     = file_read(st, faddr);
    wr_data   = '0;
    wr_en     = 1'b0;
    rate_mask = 8'((9'h002 << st.option[PS_MSB:0]) - 9'h001);
    tick      = 1'b0;
    sp_dn     = st.sp - SP_W'(1);
    next_st   = st;

    // Pin synchroniser; a bit moves only when stages two and three agree
    next_st.pin_s1    = port_pin_in;
    next_st.pin_s2    = st.pin_s1;
    next_st.pin_s3    = st.pin_s2;
    next_st.pin_level = (st.pin_s2 & st.pin_s3) | (st.pin_level & (st.pin_s2 ^ st.pin_s3));

    if (ph.cycle_en) begin
      // Timer runs from the instruction clock, through the prescaler if assigned
      if (st.option[PSA_BIT]) begin
        tick = 1'b1;
      end else begin
        next_st.prescale = st.prescale + 8'h01;
        tick = ((st.prescale & rate_mask) == rate_mask);
      end
      if (tick) begin
        next_st.timer = st.timer + 8'h01;
      end

      if (st.flush) begin
        // Second cycle of a branch: fetched word is discarded
        next_st.flush = 1'b0;
      end else begin
        next_st.pc = st.pc + PC_W'(1);
        if (op_is(instr, IDLE_MASK, IDLE_VAL)) begin
          next_st.pc = st.pc + PC_W'(1);
        end else if (op_is(instr, EXACT_MASK, RET_INT_VAL)) begin
          next_st.pc    = st.stack[sp_dn];
          next_st.sp    = sp_dn;
          next_st.int_ctl[INT_EN_BIT] = 1'b1;
          next_st.flush = 1'b1;
        end else if (op_is(instr, EXACT_MASK, RETURN_VAL)) begin
          next_st.pc    = st.stack[sp_dn];
          next_st.sp    = sp_dn;
          next_st.flush = 1'b1;
        end else if (op_is(instr, EXACT_MASK, OPTLD_VAL)) begin
          next_st.option = st.w;
        end else if (op_is(instr, LIT_MASK, RET_LIT_VAL)) begin
          next_st.w     = instr[LIT_MSB:0];
          next_st.pc    = st.stack[sp_dn];
          next_st.sp    = sp_dn;
          next_st.flush = 1'b1;
        end else if (op_is(instr, LIT_MASK, MOVLW_VAL)) begin
          next_st.w = instr[LIT_MSB:0];
        end else if (op_is(instr, JUMP_MASK, CALL_VAL)) begin
          // Overflow wraps and overwrites the oldest entry
          next_st.stack[st.sp] = st.pc + PC_W'(1);
          next_st.sp    = st.sp + SP_W'(1);
          next_st.pc    = PC_W'(instr[JUMP_MSB:0]);
          next_st.flush = 1'b1;
        end else if (op_is(instr, JUMP_MASK, GOTO_VAL)) begin
          next_st.pc    = PC_W'(instr[JUMP_MSB:0]);
          next_st.flush = 1'b1;
        end else if (op_is(instr, MOVWF_MASK, MOVWF_VAL)) begin
          wr_en   = 1'b1;
          wr_data = st.w;
        end else if (op_is(instr, FILE_MOVE_MASK, FILE_MOVE_VAL)) begin
          next_st.status[Z_BIT] = (fdata == 8'h00);
          if (instr[DEST_BIT]) begin
            wr_en   = 1'b1;
            wr_data = fdata;
          end else begin
            next_st.w = fdata;
          end
        end
        // Anything else outside this group executes as a one-cycle no-op

        // File write; a write here beats the timer tick of the same cycle
        if (wr_en) begin
          if (faddr == ADDR_TIMER) begin
            next_st.timer = wr_data;
            if (!st.option[PSA_BIT]) begin
              next_st.prescale = '0;
            end
          end else if (faddr == ADDR_OPTION) begin
            next_st.option = wr_data;
          end else if (faddr == ADDR_STATUS0 || faddr == ADDR_STATUS1) begin
            next_st.status = (wr_data & STATUS_WR_MASK) | (st.status & ~STATUS_WR_MASK);
          end else if (faddr == ADDR_PORT) begin
            next_st.latch = wr_data;
          end else if (faddr == ADDR_DIR) begin
            next_st.drive_en = ~wr_data;
          end else if (faddr == ADDR_INT_CTL0 || faddr == ADDR_INT_CTL1) begin
            next_st.int_ctl = wr_data;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are plain register fields
  assign prog_addr             = st.pc;
  assign port_pin_out          = st.latch;
  assign port_pin_oe           = st.drive_en;
  assign w_out                 = st.w;
  assign option_out            = st.option;
  assign interrupt_control_reg = st.int_ctl;
  assign timer_count_reg       = st.timer;
  assign second_cycle          = st.flush;
endmodule

// ### return_and_misc_instr_exec_sva.sv
// Concurrent checks on the ports of the return and miscellaneous execution core
`timescale 1ns/1ps
module return_and_misc_instr_exec_sva #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic                              mclk,
  input wire logic                              rst_n,
  input wire logic [misc_exec_pkg::INSTR_W-1:0] instr,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  port_pin_in,
  input wire logic [misc_exec_pkg::PC_W-1:0]    prog_addr,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  port_pin_out,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  port_pin_oe,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  w_out,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  option_out,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  interrupt_control_reg,
  input wire logic [misc_exec_pkg::DATA_W-1:0]  timer_count_reg,
  input wire logic                              second_cycle
);
  import misc_exec_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  // Nothing executes before the fourth edge, so reset values still show here
  a_reset_values: assert property ($rose(rst_n) |-> prog_addr == 13'h0000 && w_out == 8'h00
    && option_out == 8'hff && interrupt_control_reg == 8'h00 && !second_cycle)
    else $error("reset values wrong");
  a_sc_length: assert property ($rose(second_cycle) |-> second_cycle[*4] ##1 !second_cycle)
    else $error("second cycle not one instruction cycle");
  a_sc_noop: assert property ($fell(second_cycle) |-> $stable(prog_addr)
    && $stable(w_out) && $stable(option_out)) else $error("second cycle not a no-op");
  a_pc_stands: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
    else $error("program counter changed inside a cycle");
  a_w_stands: assert property ($changed(w_out) |=> $stable(w_out)[*3])
    else $error("working register changed inside a cycle");
  a_int_enable_set: assert property (instr == RET_INT_VAL && $rose(second_cycle)
    |-> interrupt_control_reg[INT_EN_BIT] && $stable(w_out)) else $error("return from interrupt");
  a_ret_lit_w: assert property ((instr & LIT_MASK) == RET_LIT_VAL && $rose(second_cycle)
    |-> w_out == instr[7:0]) else $error("literal not in working register");
  a_optld_copy: assert property (instr == OPTLD_VAL && $changed(prog_addr) |->
    option_out == w_out && !second_cycle && prog_addr == $past(prog_addr) + 13'h1)
    else $error("option load wrong");
  a_idle_only_pc: assert property ((instr & IDLE_MASK) == IDLE_VAL && $changed(prog_addr) |->
    prog_addr == $past(prog_addr) + 13'h1 && $stable(w_out) && $stable(option_out)
    && !second_cycle) else $error("no-operation changed state");
endmodule

bind return_and_misc_instr_exec return_and_misc_instr_exec_sva #(.STACK_DEPTH(STACK_DEPTH)) sva_u (
  .mclk(mclk), .rst_n(rst_n), .instr(instr), .port_pin_in(port_pin_in), .prog_addr(prog_addr),
  .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .w_out(w_out),
  .option_out(option_out), .interrupt_control_reg(interrupt_control_reg),
  .timer_count_reg(timer_count_reg), .second_cycle(second_cycle));

// ### return_and_misc_instr_exec_test.sv
// Self-checking bench for the return and miscellaneous execution core
`timescale 1ns/1ps
module return_and_misc_instr_exec_test;
  import misc_exec_pkg::*;
  typedef struct {int kind; logic [12:0] val;} note_t;
  logic        mclk;
  logic        rst_n;
  logic [13:0] instr;
  logic [7:0]  ext_pins;
  wire  [7:0]  pins;
  logic [12:0] pc;
  logic [7:0]  latch, oe, w, opt, int_ctl, timer;
  logic        sc;
  note_t       q[$];
  note_t       e;
  int          cnt = 0;
  int          errors = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'h59ce;
  logic [12:0] pc_e = 13'h0;
  logic [12:0] ret;
  logic [7:0]  r, v;

  return_and_misc_instr_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instr(instr),
    .port_pin_in(pins), .prog_addr(pc), .port_pin_out(latch), .port_pin_oe(oe),
    .w_out(w), .option_out(opt), .interrupt_control_reg(int_ctl),
    .timer_count_reg(timer), .second_cycle(sc));

  // Driven bits read back the latch, so the pin wire is resolved here
  assign pins = (oe & latch) | (~oe & ext_pins);

  // ---------------------------------------------------------------------------
  // Clock, edge count and helpers
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Every fourth edge after release is an execute edge
  always @(posedge mclk) cnt <= rst_n ? cnt + 1 : 0;

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task note(input int k, input logic [12:0] val);
    q.push_back('{k, val});
  endtask
  task cmp(input logic [12:0] got, input logic [12:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Issue one word; a jump also feeds a stray word that must be dropped
  task ex(input logic [13:0] word, input logic jmp, input logic [12:0] tgt,
          input logic [7:0] we);
    logic [7:0] j;
    instr <= word;
    pc_e = jmp ? tgt : pc_e + 13'h1;
    note(0, pc_e);
    note(1, {5'h0, we});
    note(2, {12'h0, jmp});
    repeat (4) @(posedge mclk);
    // Stray word in the second cycle: program counter and W must not move
    if (jmp) begin
      j = rnd();
      instr <= 14'h3000 | j;
      note(0, tgt);
      note(1, {5'h0, we});
      note(2, 13'h0);
      repeat (4) @(posedge mclk);
    end
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Results are settled by the falling edge after each execute edge
  always @(negedge mclk) begin
    if (cnt % 4 == 0) begin
      while (q.size() > 0) begin
        e = q.pop_front();
        case (e.kind)
          0: cmp(pc, e.val, "pc");
          1: cmp({5'h0, w}, e.val, "w");
          2: cmp({12'h0, sc}, e.val, "second");
          3: cmp({5'h0, opt}, e.val, "option");
          4: cmp({12'h0, int_ctl[INT_EN_BIT]}, e.val, "int enable");
          5: cmp({5'h0, latch}, e.val, "latch");
          6: cmp({5'h0, timer}, e.val, "timer");
          default: cmp({5'h0, oe}, e.val, "enable");
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    instr = 14'h0000;
    ext_pins = 8'h00;
    for (int k = 0; k < 8; k++) note(k, k == 3 ? 13'hff : 13'h0);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    ex(14'h0000, 0, 0, 8'h00);
    ex(14'h0060, 0, 0, 8'h00);
    r = rnd();
    ex(14'h3000 | r, 0, 0, r);
    note(3, {5'h0, r});
    ex(14'h0062, 0, 0, r);
    // Bank 1: option and direction through ordinary file access
    ex(14'h3020, 0, 0, 8'h20);
    ex(14'h0083, 0, 0, 8'h20);
    ex(14'h30c3, 0, 0, 8'hc3);
    note(3, 13'hc3);
    ex(14'h0081, 0, 0, 8'hc3);
    ex(14'h3000, 0, 0, 8'h00);
    ex(14'h0801, 0, 0, 8'hc3);
    ex(14'h300f, 0, 0, 8'h0f);
    note(7, 13'hf0);
    ex(14'h0086, 0, 0, 8'h0f);
    ex(14'h3000, 0, 0, 8'h00);
    ex(14'h0083, 0, 0, 8'h00);
    // Latch high, input pins 0 and 2 pulled down, then rewrite port from itself
    ex(14'h30ff, 0, 0, 8'hff);
    r = rnd();
    ext_pins <= r & 8'hfa;
    note(5, 13'hff);
    ex(14'h0086, 0, 0, 8'hff);
    // Driven bits need the full pin filter before the rewrite can see them
    ex(14'h0000, 0, 0, 8'hff);
    note(5, {5'h0, 8'hf0 | (r & 8'h0a)});
    ex(14'h0886, 0, 0, 8'hff);
    // Prescaler away from timer: timer ticks every cycle after a write
    ex(14'h0062, 0, 0, 8'hff);
    v = rnd();
    ex(14'h3000 | v, 0, 0, v);
    note(6, {5'h0, v});
    ex(14'h0081, 0, 0, v);
    note(6, {5'h0, 8'(v + 8'h1)});
    ex(14'h0000, 0, 0, v);
    // Prescaler on timer, divide by four; each timer write clears the prescaler, so the timer holds through the next cycle
    ex(14'h3001, 0, 0, 8'h01);
    ex(14'h0062, 0, 0, 8'h01);
    repeat (4) begin
      v = rnd();
      ex(14'h3000 | v, 0, 0, v);
      note(6, {5'h0, v});
      ex(14'h0081, 0, 0, v);
      note(6, {5'h0, v});
      ex(14'h0000, 0, 0, v);
    end
    // Nested calls, then return with literal and return from interrupt
    ret = pc_e + 13'h1;
    ex(14'h2040, 1, 13'h040, v);
    ex(14'h2123, 1, 13'h123, v);
    r = rnd();
    note(4, 13'h0);
    ex(14'h3700 | r, 1, 13'h041, r);
    note(4, 13'h1);
    ex(14'h0009, 1, ret, r);
    ex(14'h0000, 0, 0, r);
    print_verdict;
  end

  // Run needs about 200 mclk cycles; this cuts a hang short
  initial begin
    #60000;
    errors++;
    print_verdict;
  end
endmodule
